// ===== dcca_top.sv
// dcca_top: two capture/compare units, each with two reloadable time
// bases and sixteen capture/compare registers with one pin apiece.
// assumes: pins and count inputs are asynchronous; the overflow input
// is a one-cycle pulse from a timer on the same clock.
//
// Decided for this implementation: the register offsets and the Wishbone register port.
`default_nettype none

// What this block does
// - two units, sixteen channels each, thirty-two total
// - two reloadable 16-bit time bases per unit
// - time base clocked by prescaler or overflow
// - first time base may count external events
// - each channel picks timer and capture/compare
// - one pin per channel, input or output
// - capture copies timer on selected pin edge
// - each capture requests that channel's interrupt
// - capture edge rising, falling or both
// - compare modes match continuously against timer
// - mode 0 interrupts on every match
// - mode 1 toggles pin on every match
// - mode 2 one interrupt per period
// - mode 3 pin high on match, low on overflow
// - double mode, two channels toggle one pin
// - input select sets prescale 8 to 1024
// - overflow reloads timer from reload register
module dcca_top (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire dcca_pkg::dcca_wb_req_t wb_req_i,
	output logic wb_ack_o,
	output logic [31:0] wb_dat_o,
	input wire logic [dcca_pkg::NUM_CH-1:0] pin_i,
	output logic [dcca_pkg::NUM_CH-1:0] pin_o,
	output logic [dcca_pkg::NUM_CH-1:0] pin_oe_o,
	input wire logic [dcca_pkg::NUM_UNITS-1:0] cnt_in_i,
	input wire logic ovf_in_i,
	output logic [dcca_pkg::NUM_CH-1:0] cc_irq_o,
	output logic [dcca_pkg::NUM_TMR-1:0] tmr_irq_o
);

	// ==========================================================
	// state and helpers
	// ==========================================================
	dcca_pkg::dcca_state_t s_reg; // all state of the block
	dcca_pkg::dcca_state_t s_next; // its next value
	logic [dcca_pkg::NUM_TMR-1:0] tick; // time base advances now
	logic [dcca_pkg::NUM_TMR-1:0] ovf; // time base wraps now
	logic [dcca_pkg::NUM_CH-1:0] capd; // capture happened this cycle

	// prescaler mask: all ones below the selected factor
	function automatic logic [dcca_pkg::PRE_W-1:0] pre_mask(input logic [2:0] sel);
		pre_mask = dcca_pkg::PRE_W'((dcca_pkg::PRE_BASE << sel) - 10'h001);
	endfunction

	// channel drives its pin in compare modes 1 and 3, and as the lower channel in double mode
	function automatic logic ch_drives(input logic [4:0] cfg, input int k);
		case (cfg[3:0])
			dcca_pkg::CM_CMP1, dcca_pkg::CM_CMP3: begin
				ch_drives = 1'b1;
			end
			dcca_pkg::CM_DBL: begin
				ch_drives = (k < dcca_pkg::DBL_SPAN);
			end
			default: begin
				ch_drives = 1'b0;
			end
		endcase
	endfunction

	// byte-enable merge of a 16-bit field
	function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
		input logic [3:0] sel);
		merge16 = {sel[1] ? d[15:8] : old[15:8], sel[0] ? d[7:0] : old[7:0]};
	endfunction

	// address lies inside the map; bits above the unit bit stay zero
	function automatic logic adr_ok(input logic [dcca_pkg::ADR_W-1:0] adr);
		adr_ok = (adr[dcca_pkg::ADR_W-1:dcca_pkg::ADR_UNIT_BIT+1] == 2'h0) && !adr[8];
	endfunction

	// read mux; unmapped words read as zero
	function automatic logic [31:0] rd_word(input dcca_pkg::dcca_state_t st,
		input logic [dcca_pkg::ADR_W-1:0] adr);
		int u;
		int c;
		logic [7:0] o;
		u = int'(adr[dcca_pkg::ADR_UNIT_BIT]);
		o = {adr[7:2], 2'h0};
		c = u * dcca_pkg::CH_PER_UNIT + int'(o[5:2]);
		rd_word = 32'h0000_0000;
		if (adr_ok(adr)) begin
			if (o == dcca_pkg::OFS_TCTL0 || o == dcca_pkg::OFS_TCTL1) begin
				rd_word = {26'h0, st.tmr[u*2 + int'(o[2])].ctl};
			end else if (o == dcca_pkg::OFS_RLD0 || o == dcca_pkg::OFS_RLD1) begin
				rd_word = {16'h0, st.tmr[u*2 + int'(o[2])].reload};
			end else if (o == dcca_pkg::OFS_CNT0 || o == dcca_pkg::OFS_CNT1) begin
				rd_word = {16'h0, st.tmr[u*2 + int'(o[2])].cnt};
			end else if (o == dcca_pkg::OFS_PINS) begin
				// upper half: driven levels, lower half: sampled levels
				for (int k = 0; k < dcca_pkg::CH_PER_UNIT; k++) begin
					rd_word[16+k] = st.ch[u*dcca_pkg::CH_PER_UNIT + k].pin;
					rd_word[k] = st.pin_s2[u*dcca_pkg::CH_PER_UNIT + k];
				end
			end else if (o[7:6] == dcca_pkg::BLK_MODE) begin
				rd_word = {27'h0, st.ch[c].cfg};
			end else if (o[7:6] == dcca_pkg::BLK_VAL) begin
				rd_word = {16'h0, st.ch[c].val};
			end
		end
	endfunction

	// ==========================================================
	// next-state logic
	// ==========================================================
	// one process for timers, channels and the bus; bus writes come
	// last so software wins, except a capture wins over a value write
	always_comb begin
		int t;
		int k;
		int u;
		int c;
		logic [15:0] tv;
		logic hit;
		logic hitp;
		logic rise;
		logic fall;
		logic [7:0] o;
		logic wr;
		t = 0;
		k = 0;
		u = 0;
		c = 0;
		tv = 16'h0000;
		hit = 1'b0;
		hitp = 1'b0;
		rise = 1'b0;
		fall = 1'b0;
		o = 8'h00;
		wr = 1'b0;
		s_next = s_reg;
		tick = '0;
		ovf = '0;
		capd = '0;
		// free-running prescaler shared by all time bases
		s_next.pre = dcca_pkg::PRE_W'(s_reg.pre + 10'h001);
		// two flip-flops on every asynchronous input
		s_next.pin_s1 = pin_i;
		s_next.pin_s2 = s_reg.pin_s1;
		s_next.pin_p = s_reg.pin_s2;
		s_next.cnt_s1 = cnt_in_i;
		s_next.cnt_s2 = s_reg.cnt_s1;
		s_next.cnt_p = s_reg.cnt_s2;
		s_next.cc_irq = '0;
		s_next.tmr_irq = '0;

		// time bases: four of them, two per unit
		for (int i = 0; i < dcca_pkg::NUM_TMR; i++) begin
			u = i / 2;
			if (s_reg.tmr[i].ctl[dcca_pkg::TCTL_RUN_BIT]) begin
				case (s_reg.tmr[i].ctl[dcca_pkg::TCTL_SRC_LSB +: 2])
					dcca_pkg::SRC_PRESCALE: begin
						tick[i] = ((s_reg.pre & pre_mask(s_reg.tmr[i].ctl[2:0]))
							== pre_mask(s_reg.tmr[i].ctl[2:0]));
					end
					dcca_pkg::SRC_OVF: begin
						tick[i] = ovf_in_i;
					end
					dcca_pkg::SRC_COUNT: begin
						// only the first time base of a unit has a count input
						tick[i] = (i % 2 == 0) && s_reg.cnt_s2[u] && !s_reg.cnt_p[u];
					end
					default: begin
						tick[i] = 1'b0;
					end
				endcase
			end
			ovf[i] = tick[i] && (s_reg.tmr[i].cnt == dcca_pkg::TMR_TOP);
			s_next.tmr[i].tick_d = tick[i];
			if (ovf[i]) begin
				s_next.tmr[i].cnt = s_reg.tmr[i].reload;
			end else if (tick[i]) begin
				s_next.tmr[i].cnt = 16'(s_reg.tmr[i].cnt + 16'h0001);
			end
			s_next.tmr_irq[i] = ovf[i];
		end

		// channels: 16 per unit, each on its chosen time base
		for (int i = 0; i < dcca_pkg::NUM_CH; i++) begin
			u = i / dcca_pkg::CH_PER_UNIT;
			k = i % dcca_pkg::CH_PER_UNIT;
			t = u * 2 + int'(s_reg.ch[i].cfg[dcca_pkg::CH_TSEL_BIT]);
			tv = s_reg.tmr[t].cnt;
			// a match counts once, in the cycle after the timer moved
			hit = s_reg.tmr[t].tick_d && (tv == s_reg.ch[i].val);
			hitp = s_reg.tmr[t].tick_d && (tv == s_reg.ch[(i + dcca_pkg::DBL_SPAN) % 32].val);
			rise = s_reg.pin_s2[i] && !s_reg.pin_p[i];
			fall = !s_reg.pin_s2[i] && s_reg.pin_p[i];
			// overflow starts a new period; mode 3 pin drops here
			if (ovf[t]) begin
				s_next.ch[i].armed = 1'b1;
				if (s_reg.ch[i].cfg[3:0] == dcca_pkg::CM_CMP3) begin
					s_next.ch[i].pin = 1'b0;
				end
			end
			case (s_reg.ch[i].cfg[3:0])
				dcca_pkg::CM_CAP_RISE, dcca_pkg::CM_CAP_FALL, dcca_pkg::CM_CAP_BOTH: begin
					if ((rise && s_reg.ch[i].cfg[0]) || (fall && s_reg.ch[i].cfg[1])) begin
						s_next.ch[i].val = tv;
						s_next.cc_irq[i] = 1'b1;
						capd[i] = 1'b1;
					end
				end
				dcca_pkg::CM_CMP0: begin
					s_next.cc_irq[i] = hit;
				end
				dcca_pkg::CM_CMP1: begin
					if (hit) begin
						s_next.ch[i].pin = !s_reg.ch[i].pin;
					end
				end
				dcca_pkg::CM_CMP2: begin
					if (hit && s_reg.ch[i].armed) begin
						s_next.cc_irq[i] = 1'b1;
						s_next.ch[i].armed = 1'b0;
					end
				end
				dcca_pkg::CM_CMP3: begin
					if (hit && s_reg.ch[i].armed) begin
						s_next.ch[i].pin = 1'b1;
						s_next.ch[i].armed = 1'b0;
					end
				end
				dcca_pkg::CM_DBL: begin
					// lower channel owns the pin, its upper partner adds a match
					if (k < dcca_pkg::DBL_SPAN && (hit || hitp)) begin
						s_next.ch[i].pin = !s_reg.ch[i].pin;
					end
				end
				default: begin
					s_next.ch[i].armed = s_next.ch[i].armed;
				end
			endcase
		end

		// wishbone: ack one cycle after the strobe, dropped the next
		s_next.ack = wb_req_i.cyc && wb_req_i.stb && !s_reg.ack;
		if (wb_req_i.cyc && wb_req_i.stb && !s_reg.ack) begin
			s_next.dat = rd_word(s_reg, wb_req_i.adr);
		end
		// a write lands on the edge that sees ack high
		wr = wb_req_i.cyc && wb_req_i.stb && wb_req_i.we && s_reg.ack
			&& adr_ok(wb_req_i.adr);
		u = int'(wb_req_i.adr[dcca_pkg::ADR_UNIT_BIT]);
		o = {wb_req_i.adr[7:2], 2'h0};
		c = u * dcca_pkg::CH_PER_UNIT + int'(o[5:2]);
		t = u * 2 + int'(o[2]);
		if (wr) begin
			if ((o == dcca_pkg::OFS_TCTL0 || o == dcca_pkg::OFS_TCTL1) && wb_req_i.sel[0]) begin
				s_next.tmr[t].ctl = wb_req_i.dat[5:0];
			end else if (o == dcca_pkg::OFS_RLD0 || o == dcca_pkg::OFS_RLD1) begin
				s_next.tmr[t].reload = merge16(s_reg.tmr[t].reload, wb_req_i.dat, wb_req_i.sel);
			end else if (o == dcca_pkg::OFS_CNT0 || o == dcca_pkg::OFS_CNT1) begin
				s_next.tmr[t].cnt = merge16(s_reg.tmr[t].cnt, wb_req_i.dat, wb_req_i.sel);
			end else if (o[7:6] == dcca_pkg::BLK_MODE && wb_req_i.sel[0]) begin
				// new mode starts armed so its first period is not lost
				s_next.ch[c].cfg = wb_req_i.dat[4:0];
				s_next.ch[c].armed = 1'b1;
			end else if (o[7:6] == dcca_pkg::BLK_VAL && !capd[c]) begin
				s_next.ch[c].val = merge16(s_reg.ch[c].val, wb_req_i.dat, wb_req_i.sel);
			end
		end
	end

	// ==========================================================
	// state register
	// ==========================================================
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s_reg <= dcca_pkg::STATE_RST;
		end else begin
			s_reg <= s_next;
		end
	end

	// ==========================================================
	// outputs
	// ==========================================================
	// enables follow the mode directly; levels come from flip-flops
	for (genvar g = 0; g < dcca_pkg::NUM_CH; g++) begin : g_pin
		assign pin_o[g] = s_reg.ch[g].pin;
		assign pin_oe_o[g] = ch_drives(s_reg.ch[g].cfg, g % dcca_pkg::CH_PER_UNIT);
	end
	assign wb_ack_o = s_reg.ack;
	assign wb_dat_o = s_reg.dat;
	assign cc_irq_o = s_reg.cc_irq;
	assign tmr_irq_o = s_reg.tmr_irq;

endmodule

`default_nettype wire

// ===== dcca_pkg.sv
// dcca_pkg: constants, field layout and carrier types for the dual
// capture/compare array.
// assumes: one 10 MHz clock, classic wishbone slave with 32-bit data.
`default_nettype none

package dcca_pkg;

	// ==========================================================
	// array shape
	// ==========================================================
	localparam int NUM_UNITS = 2; // capture/compare units
	localparam int CH_PER_UNIT = 16; // registers per unit
	localparam int NUM_CH = 32; // registers in total
	localparam int NUM_TMR = 4; // two time bases per unit
	localparam int DBL_SPAN = 8; // double mode pairs channel k with k+8

	// ==========================================================
	// register map (byte offsets inside one unit)
	// ==========================================================
	localparam int ADR_W = 12; // decoded address bits
	localparam int ADR_UNIT_BIT = 9; // selects unit a or unit b
	localparam logic [7:0] OFS_TCTL0 = 8'h00; // first time base control
	localparam logic [7:0] OFS_TCTL1 = 8'h04; // second time base control
	localparam logic [7:0] OFS_RLD0 = 8'h08; // first time base reload
	localparam logic [7:0] OFS_RLD1 = 8'h0C; // second time base reload
	localparam logic [7:0] OFS_CNT0 = 8'h10; // first time base count
	localparam logic [7:0] OFS_CNT1 = 8'h14; // second time base count
	localparam logic [7:0] OFS_PINS = 8'h18; // pin levels, read only
	localparam logic [1:0] BLK_MODE = 2'h1; // 0x40..0x7C channel modes
	localparam logic [1:0] BLK_VAL = 2'h2; // 0x80..0xBC channel values

	// ==========================================================
	// time base control fields
	// ==========================================================
	localparam int TCTL_SEL_LSB = 0; // timer_input_select, 3 bits
	localparam int TCTL_SRC_LSB = 3; // clock source, 2 bits
	localparam int TCTL_RUN_BIT = 5; // count enable
	localparam logic [1:0] SRC_PRESCALE = 2'h0; // prescaled system clock
	localparam logic [1:0] SRC_OVF = 2'h1; // external timer overflow
	localparam logic [1:0] SRC_COUNT = 2'h2; // external count input
	localparam int PRE_W = 10; // prescaler width, reaches 1024
	localparam logic [PRE_W-1:0] PRE_BASE = 10'h008; // factor at code 000b
	localparam logic [15:0] TMR_TOP = 16'hFFFF; // last count before wrap

	// ==========================================================
	// channel mode field (bits 3:0) and timer select (bit 4)
	// ==========================================================
	localparam int CH_TSEL_BIT = 4;
	typedef enum logic [3:0] {
		CM_OFF = 4'h0,
		CM_CAP_RISE = 4'h1,
		CM_CAP_FALL = 4'h2,
		CM_CAP_BOTH = 4'h3,
		CM_CMP0 = 4'h4,
		CM_CMP1 = 4'h5,
		CM_CMP2 = 4'h6,
		CM_CMP3 = 4'h7,
		CM_DBL = 4'h8
	} dcca_mode_t;

	// ==========================================================
	// carrier types
	// ==========================================================
	typedef struct packed {
		logic cyc;
		logic stb;
		logic we;
		logic [3:0] sel;
		logic [ADR_W-1:0] adr;
		logic [31:0] dat;
	} dcca_wb_req_t;

	typedef struct packed {
		logic [15:0] cnt; // running count
		logic [15:0] reload; // value loaded on overflow
		logic [5:0] ctl; // run, source, input select
		logic tick_d; // count changed last cycle
	} dcca_tmr_t;

	typedef struct packed {
		logic [4:0] cfg; // timer select and mode
		logic [15:0] val; // capture/compare value
		logic armed; // one event left in this period
		logic pin; // driven pin level
	} dcca_ch_t;

	typedef struct packed {
		dcca_tmr_t [NUM_TMR-1:0] tmr;
		dcca_ch_t [NUM_CH-1:0] ch;
		logic [PRE_W-1:0] pre;
		logic [NUM_CH-1:0] pin_s1;
		logic [NUM_CH-1:0] pin_s2;
		logic [NUM_CH-1:0] pin_p;
		logic [NUM_UNITS-1:0] cnt_s1;
		logic [NUM_UNITS-1:0] cnt_s2;
		logic [NUM_UNITS-1:0] cnt_p;
		logic ack;
		logic [31:0] dat;
		logic [NUM_CH-1:0] cc_irq;
		logic [NUM_TMR-1:0] tmr_irq;
	} dcca_state_t;

	localparam dcca_state_t STATE_RST = '0; // everything stopped and low

endpackage

`default_nettype wire

// ===== dcca_assertions.sv
// dcca_assertions: bus and pin checks on the capture/compare array ports.
// assumes: bound to dcca_top from the bench; one clock, synchronous reset.
`default_nettype none
module dcca_assertions (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire dcca_pkg::dcca_wb_req_t wb_req_i,
	input wire logic wb_ack_o,
	input wire logic [31:0] wb_dat_o,
	input wire logic [dcca_pkg::NUM_CH-1:0] pin_o,
	input wire logic [dcca_pkg::NUM_CH-1:0] pin_oe_o,
	input wire logic [dcca_pkg::NUM_CH-1:0] cc_irq_o,
	input wire logic [dcca_pkg::NUM_TMR-1:0] tmr_irq_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// ==========================================================
	// helper: a request not yet answered
	// ==========================================================
	logic req; // taken at the next edge
	assign req = wb_req_i.cyc && wb_req_i.stb && !wb_ack_o;
	// ==========================================================
	// bus handshake
	// ==========================================================
	ack_latency_a: assert property (req |=> wb_ack_o) else $error("request not answered");
	ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than a cycle");
	ack_cause_a: assert property (wb_ack_o |-> $past(req)) else $error("ack without request");
	dat_hold_a: assert property (!wb_ack_o |-> $stable(wb_dat_o)) else $error("read data moved");
	unmapped_zero_a: assert property (req && !wb_req_i.we && wb_req_i.adr[11:10] != 2'h0
		|=> wb_dat_o == 32'h0) else $error("unmapped read not zero");
	// ==========================================================
	// reset and pins; reset check ignores the default disable
	// ==========================================================
	reset_quiet_a: assert property (disable iff (1'b0) rst_i |=> !wb_ack_o && pin_o == '0
		&& cc_irq_o == '0 && tmr_irq_o == '0) else $error("outputs live in reset");
	pin_owned_a: assert property (((pin_o ^ $past(pin_o)) & ~pin_oe_o & ~$past(pin_oe_o)) == '0)
		else $error("undriven pin moved");
	pin_readback_a: assert property (wb_ack_o && !$past(wb_req_i.we)
		&& $past(wb_req_i.adr) == 12'h018 |-> wb_dat_o[31:16] == $past(pin_o[15:0]))
		else $error("pin readback wrong");
endmodule
`default_nettype wire

// ===== dcca_partner.sv
// dcca_partner: outside world of the array: pin wires and overflow pulses.
// assumes: same clock as the array; bench supplies external pin levels.
`default_nettype none
module dcca_partner #(
	parameter int GAP = 5 // cycles between overflow pulses
) (
	input wire logic clk_i,
	input wire logic [31:0] drv_i,
	input wire logic [31:0] oe_i,
	input wire logic [31:0] ext_i,
	input wire logic ovf_go_i,
	output logic [31:0] lvl_o,
	output logic ovf_o
);
	int gap_cnt = 0; // spacing of overflow pulses
	initial ovf_o = 1'b0;
	// wire level: driver wins where it enables, else the outside source
	assign lvl_o = (drv_i & oe_i) | (ext_i & ~oe_i);
	// one-cycle overflow pulse every GAP cycles while enabled
	always @(posedge clk_i) begin
		ovf_o <= 1'b0;
		if (ovf_go_i) begin
			gap_cnt <= (gap_cnt == GAP - 1) ? 0 : gap_cnt + 1;
			if (gap_cnt == GAP - 1) ovf_o <= 1'b1;
		end
	end
endmodule
`default_nettype wire

// ===== test_dcca_top.sv
// test_dcca_top: directed bench for the capture/compare array.
// assumes: dcca_pkg, dcca_top, dcca_partner, dcca_assertions compiled before.
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin num_errors++; \
	$display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (b)); end end
module test_dcca_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	dcca_pkg::dcca_wb_req_t req = '0;
	logic wb_ack_o, ovf_i, p0_d = 1'b0, ovf_go = 1'b0;
	logic [31:0] wb_dat_o, rd, pin_i, pin_o, pin_oe_o, cc_irq_o, ext = '0;
	logic [1:0] cnt_in = '0;
	logic [3:0] tmr_irq_o;
	int num_errors = 0, checks_done = 0, pchg = 0;
	int tic[4], ccn[32];
	always #50 clk_i = ~clk_i;
	dcca_top dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(req), .wb_ack_o(wb_ack_o),
		.wb_dat_o(wb_dat_o), .pin_i(pin_i), .pin_o(pin_o), .pin_oe_o(pin_oe_o),
		.cnt_in_i(cnt_in), .ovf_in_i(ovf_i), .cc_irq_o(cc_irq_o), .tmr_irq_o(tmr_irq_o));
	dcca_partner #(.GAP(5)) far_u (.clk_i(clk_i), .drv_i(pin_o), .oe_i(pin_oe_o),
		.ext_i(ext), .ovf_go_i(ovf_go), .lvl_o(pin_i), .ovf_o(ovf_i));
	// tallies at the edge, so registered outputs are still pre-edge
	always @(posedge clk_i) begin
		for (int i = 0; i < 4; i++) tic[i] += tmr_irq_o[i];
		for (int i = 0; i < 32; i++) ccn[i] += cc_irq_o[i];
		pchg += int'(pin_o[0] != p0_d);
		p0_d <= pin_o[0];
	end
	// ==========================================================
	// shared tasks
	// ==========================================================
	task automatic report_and_stop();
		$display("errors %0d checks %0d", num_errors, checks_done);
		if (num_errors == 0 && checks_done > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	// one classic cycle; ack and read data taken at the rising edge
	// that samples ack high, and only then is the request released
	task automatic wb(input logic we, input logic [11:0] a, input logic [31:0] d);
		int n = 0;
		@(posedge clk_i);
		req <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: 4'hF, adr: a, dat: d};
		do @(posedge clk_i); while (wb_ack_o !== 1'b1 && ++n < 20);
		rd = wb_dat_o;
		if (n >= 20) num_errors++;
		req <= '0;
	endtask
	task automatic wait_irq(input int i);
		int n = 0;
		do @(negedge clk_i); while (tmr_irq_o[i] !== 1'b1 && ++n < 2100);
		if (n >= 2100) num_errors++;
	endtask
	// cleared off the edge to avoid racing the tallies
	task automatic zero();
		@(negedge clk_i);
		tic = '{default: 0};
		ccn = '{default: 0};
		pchg = 0;
		// back on the rising edge so the next stimulus is launched there
		@(posedge clk_i);
	endtask
	// ==========================================================
	// scenarios
	// ==========================================================
	task automatic t_reset();
		wb(0, 12'h010, 32'h0);
		`CHK(rd, 32'h0)
		wb(0, 12'h040, 32'h0);
		`CHK(rd, 32'h0)
		wb(1, 12'hC00, 32'hFFFFFFFF);
		wb(0, 12'hC00, 32'h0);
		`CHK(rd, 32'h0)
	endtask
	// reload FFFF wraps each tick, so the irq spacing is the prescale
	task automatic t_prescale();
		int n;
		for (int s = 0; s < 8; s++) begin
			wb(1, 12'h008, 32'hFFFF);
			wb(1, 12'h010, 32'hFFFF);
			wb(1, 12'h000, 32'h20 | s);
			wait_irq(0);
			n = 0;
			do begin @(negedge clk_i); n++; end while (tmr_irq_o[0] !== 1'b1 && n < 2000);
			`CHK(n, 8 << s)
		end
		wb(1, 12'h008, 32'h1234);
		wb(1, 12'h010, 32'hFFFF);
		wb(1, 12'h000, 32'h27);
		wait_irq(0);
		wb(1, 12'h000, 32'h0);
		wb(0, 12'h010, 32'h0);
		`CHK(rd[15:0], 16'h1234)
	endtask
	// overflow source on a's second base, count input on both b bases
	task automatic t_sources();
		wb(1, 12'h00C, 32'hFFFF);
		wb(1, 12'h014, 32'hFFFF);
		wb(1, 12'h004, 32'h28);
		for (int t = 0; t < 2; t++) begin
			wb(1, 12'h208 + 12'(4 * t), 32'hFFFF);
			wb(1, 12'h210 + 12'(4 * t), 32'hFFFF);
			wb(1, 12'h200 + 12'(4 * t), 32'h30);
		end
		zero();
		@(posedge clk_i);
		ovf_go <= 1'b1;
		repeat (15) @(posedge clk_i);
		ovf_go <= 1'b0;
		repeat (3) begin
			cnt_in <= 2'b10;
			repeat (4) @(posedge clk_i);
			cnt_in <= 2'b00;
			repeat (4) @(posedge clk_i);
		end
		repeat (6) @(posedge clk_i);
		`CHK(tic[1], 3)
		`CHK(tic[2], 3)
		`CHK(tic[3], 0)
		wb(1, 12'h004, 32'h0);
		wb(1, 12'h200, 32'h0);
		wb(1, 12'h204, 32'h0);
	endtask
	// stopped timers give exact captures; unit b uses its second base
	task automatic t_capture();
		logic [11:0] a;
		int c;
		for (int u = 0; u < 2; u++) for (int m = 1; m < 4; m++) begin
			a = 12'(u * 32'h200);
			c = u * 16 + 1;
			wb(1, a + 12'h010, m * 32'h111);
			wb(1, a + 12'h014, m * 32'h222);
			wb(1, a + 12'h044, m | (u << 4));
			zero();
			ext[c] <= 1'b1;
			repeat (8) @(posedge clk_i);
			`CHK(ccn[c], int'(m != 2))
			ext[c] <= 1'b0;
			repeat (8) @(posedge clk_i);
			`CHK(ccn[c], (m == 3) ? 2 : 1)
			wb(0, a + 12'h084, 32'h0);
			`CHK(rd[15:0], 16'(m * (u + 1) * 32'h111))
		end
	endtask
	// two passes over the match value per period, then a wrap
	task automatic t_compare();
		logic [3:0] md [5] = '{4'h4, 4'h6, 4'h5, 4'h7, 4'h8};
		int chg [5] = '{0, 0, 2, 2, 4};
		wb(1, 12'h008, 32'h0);
		wb(1, 12'h080, 32'hFFFA);
		wb(1, 12'h0A0, 32'hFFFB);
		for (int i = 0; i < 5; i++) begin
			wb(1, 12'h000, 32'h0);
			wb(1, 12'h010, 32'hFFF9);
			wb(1, 12'h040, 32'(md[i]));
			zero();
			wb(1, 12'h000, 32'h20);
			repeat (20) @(posedge clk_i);
			wb(1, 12'h010, 32'hFFF9);
			repeat (20) @(posedge clk_i);
			if (i < 2) `CHK(ccn[0], 2 - i)
			repeat (48) @(posedge clk_i);
			`CHK(pchg, chg[i])
			`CHK(pin_oe_o[0], i > 1)
			if (i == 3) `CHK(pin_o[0], 1'b0)
		end
		wb(1, 12'h000, 32'h0);
	endtask
	// ==========================================================
	// main sequence and watchdog
	// ==========================================================
	initial begin
		repeat (16) @(posedge clk_i);
		rst_i <= 1'b0;
		t_reset();
		t_prescale();
		t_sources();
		t_capture();
		t_compare();
		report_and_stop();
	end
	initial begin
		repeat (40000) @(posedge clk_i);
		num_errors++;
		report_and_stop();
	end
endmodule
bind dcca_top dcca_assertions chk_u (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(wb_req_i),
	.wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .pin_o(pin_o), .pin_oe_o(pin_oe_o),
	.cc_irq_o(cc_irq_o), .tmr_irq_o(tmr_irq_o));
`default_nettype wire
